// ==== hw/sectored_data_memory_addressing.v ====
// Data memory address resolution, core registers, display bytes and accumulator
`include "sectored_memory_defs.vh"

module sectored_data_memory_addressing (
   input  wire         sys_clk,
   input  wire         nrst,
   input  wire         req,
   input  wire [2:0]   op,
   input  wire         ext_addr,
   input  wire [7:0]   sector,
   input  wire [7:0]   addr,
   input  wire [2:0]   bit_sel,
   input  wire [7:0]   alu_result,
   input  wire [7:0]   pc_low_now,
   input  wire [7:0]   ext_sfr_rdata,
   input  wire         ext_sfr_hit,
   input  wire         ext_sfr_ro,
   output reg          busy,
   output reg          done,
   output reg  [7:0]   read_data,
   output reg  [7:0]   acc,
   output reg          pc_load,
   output reg  [7:0]   pc_load_value,
   output reg          pc_dummy,
   output reg          ext_sfr_sel,
   output reg          ext_sfr_nvm,
   output reg  [7:0]   ext_sfr_addr,
   output reg  [7:0]   ext_sfr_wdata,
   output reg          ext_sfr_we,
   output wire [159:0] lcd_segments
);

   // ------------------------------------------------
   // Local codes
   // ------------------------------------------------
   localparam [1:0] S_IDLE  = 2'd0;
   localparam [1:0] S_FETCH = 2'd1;
   localparam [1:0] S_EXEC  = 2'd2;
   localparam [1:0] S_DUMMY = 2'd3;

   localparam [2:0] R_NONE = 3'd0;
   localparam [2:0] R_RAM  = 3'd1;
   localparam [2:0] R_LCD  = 3'd2;
   localparam [2:0] R_IND  = 3'd3;
   localparam [2:0] R_CORE = 3'd4;
   localparam [2:0] R_EXT  = 3'd5;
   localparam [2:0] R_NVM  = 3'd6;

   // ------------------------------------------------
   // Reset release
   // ------------------------------------------------
   reg rst_meta;
   reg rst_n;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------
   // Region decode, applied to direct and pointed addresses
   // ------------------------------------------------
   function [2:0] region;
      input [7:0] sec;
      input [7:0] off;
      begin
         if ((sec == `SEC_ZERO || sec == `SEC_ONE) && off >= `GP_BASE) begin
            region = R_RAM;
         end else if (sec == `SEC_LCD && off <= `LCD_LAST) begin
            region = R_LCD;
         end else if (sec == `SEC_ZERO &&
                      (off == `OFS_IND_S0 || off == `OFS_IND_A || off == `OFS_IND_B)) begin
            region = R_IND;
         end else if (sec == `SEC_ZERO && off <= `OFS_PTR_B_SEC) begin
            region = R_CORE;
         end else if (sec == `SEC_ZERO) begin
            region = R_EXT;
         end else if (sec == `SEC_ONE && off == `NVM_CTRL_OFS) begin
            region = R_NVM;
         end else begin
            region = R_NONE;
         end
      end
   endfunction

   // ------------------------------------------------
   // State
   // ------------------------------------------------
   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] req_op;
   reg [2:0] req_bit;
   reg [7:0] req_alu;
   reg [7:0] tgt_sec;
   reg [7:0] tgt_off;
   reg [2:0] tgt_reg;

   reg [7:0] ptr_s0;
   reg [7:0] ptr_a_low;
   reg [7:0] ptr_a_sec;
   reg [7:0] ptr_b_low;
   reg [7:0] ptr_b_sec;
   reg [7:0] lcd_byte [0:`LCD_BYTES-1];

   wire [7:0] ram_q;

   // ------------------------------------------------
   // Address resolution of an incoming request
   // ------------------------------------------------
   reg  [7:0] dir_sec;
   reg  [7:0] res_sec;
   reg  [7:0] res_off;
   reg  [2:0] dir_reg;

   always @* begin
      dir_sec = ext_addr ? sector : `SEC_ZERO;
      dir_reg = region(dir_sec, addr);
      res_sec = dir_sec;
      res_off = addr;
      if (dir_reg == R_IND) begin
         if (addr == `OFS_IND_S0) begin
            res_sec = `SEC_ZERO;
            res_off = ptr_s0;
         end else if (addr == `OFS_IND_A) begin
            res_sec = ptr_a_sec;
            res_off = ptr_a_low;
         end else begin
            res_sec = ptr_b_sec;
            res_off = ptr_b_low;
         end
      end
   end

   // ------------------------------------------------
   // Current value of the target location
   // ------------------------------------------------
   reg [7:0] cur;

   always @* begin
      cur = 8'h00;
      case (tgt_reg)
         R_RAM:  cur = ram_q;
         R_LCD:  cur = lcd_byte[tgt_off[4:0]];
         R_IND:  cur = 8'h00;
         R_EXT:  cur = ext_sfr_hit ? ext_sfr_rdata : 8'h00;
         R_NVM:  cur = ext_sfr_hit ? ext_sfr_rdata : 8'h00;
         R_CORE: begin
            case (tgt_off)
               `OFS_PTR_S0:    cur = ptr_s0;
               `OFS_PTR_A_LOW: cur = ptr_a_low;
               `OFS_PTR_A_SEC: cur = ptr_a_sec;
               `OFS_PTR_B_LOW: cur = ptr_b_low;
               `OFS_PTR_B_SEC: cur = ptr_b_sec;
               `OFS_ACC:       cur = acc;
               `OFS_PC_LOW:    cur = pc_low_now;
               default:        cur = 8'h00;
            endcase
         end
         default: cur = 8'h00;
      endcase
   end

   // ------------------------------------------------
   // Value written back and write qualifiers
   // ------------------------------------------------
   reg [7:0] wval;
   reg       writes;

   always @* begin
      wval   = cur;
      writes = 1'b1;
      case (req_op)
         `OP_STORE: wval = acc;
         `OP_BSET:  wval = cur | (8'h01 << req_bit);
         `OP_BCLR:  wval = cur & ~(8'h01 << req_bit);
         `OP_INC:   wval = cur + 8'h01;
         `OP_DEC:   wval = cur - 8'h01;
         default:   writes = 1'b0;
      endcase
   end

   wire exec_wr   = (state == S_EXEC) && writes;
   wire core_wr   = exec_wr && (tgt_reg == R_CORE);
   wire pcl_wr    = core_wr && (tgt_off == `OFS_PC_LOW);
   wire ram_we    = exec_wr && (tgt_reg == R_RAM);
   wire needs_rd  = (op != `OP_STORE) && (op != `OP_ALU);

   data_ram u_ram (
      .clk   (sys_clk),
      .we    (ram_we),
      .re    (state == S_FETCH),
      .addr  ({tgt_sec[0], tgt_off[6:0]}),
      .wdata (wval),
      .rdata (ram_q)
   );

   // ------------------------------------------------
   // Sequencer
   // ------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (req && op != `OP_NOP) begin
               next_state = needs_rd ? S_FETCH : S_EXEC;
            end
         end
         S_FETCH: next_state = S_EXEC;
         S_EXEC:  next_state = pcl_wr ? S_DUMMY : S_IDLE;
         S_DUMMY: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= S_IDLE;
         busy      <= 1'b0;
         done      <= 1'b0;
         req_op    <= `OP_NOP;
         req_bit   <= 3'h0;
         req_alu   <= 8'h00;
         tgt_sec   <= 8'h00;
         tgt_off   <= 8'h00;
         tgt_reg   <= R_NONE;
         read_data <= 8'h00;
      end else begin
         state <= next_state;
         busy  <= (next_state != S_IDLE);
         done  <= (state == S_EXEC && next_state == S_IDLE) || (state == S_DUMMY);
         if (state == S_IDLE && req && op != `OP_NOP) begin
            req_op  <= op;
            req_bit <= bit_sel;
            req_alu <= alu_result;
            tgt_sec <= res_sec;
            tgt_off <= res_off;
            // A pointer aimed back at an indirect port gets nothing
            tgt_reg <= region(res_sec, res_off);
         end
         if (state == S_EXEC && req_op == `OP_LOAD) begin
            read_data <= cur;
         end
      end
   end

   // ------------------------------------------------
   // Accumulator and pointers
   // ------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc       <= `ACC_RST;
         ptr_s0    <= `PTR_RST;
         ptr_a_low <= `PTR_RST;
         ptr_a_sec <= `PTR_RST;
         ptr_b_low <= `PTR_RST;
         ptr_b_sec <= `PTR_RST;
      end else if (state == S_EXEC) begin
         if (req_op == `OP_ALU) begin
            acc <= req_alu;
         end else if (req_op == `OP_LOAD) begin
            acc <= cur;
         end else if (core_wr && tgt_off == `OFS_ACC) begin
            acc <= wval;
         end
         if (core_wr) begin
            case (tgt_off)
               `OFS_PTR_S0:    ptr_s0    <= wval;
               `OFS_PTR_A_LOW: ptr_a_low <= wval;
               `OFS_PTR_A_SEC: ptr_a_sec <= wval;
               `OFS_PTR_B_LOW: ptr_b_low <= wval;
               `OFS_PTR_B_SEC: ptr_b_sec <= wval;
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------
   // Program counter low byte
   // ------------------------------------------------
   // The core keeps the upper counter bits, so the jump stays in its page
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_load       <= 1'b0;
         pc_load_value <= 8'h00;
         pc_dummy      <= 1'b0;
      end else begin
         pc_load  <= pcl_wr;
         pc_dummy <= pcl_wr;
         if (pcl_wr) begin
            pc_load_value <= wval;
         end
      end
   end

   // ------------------------------------------------
   // Peripheral register port
   // ------------------------------------------------
   // The write strobe lags one cycle; address and data stay put meanwhile
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sfr_sel   <= 1'b0;
         ext_sfr_nvm   <= 1'b0;
         ext_sfr_addr  <= 8'h00;
         ext_sfr_wdata <= 8'h00;
         ext_sfr_we    <= 1'b0;
      end else begin
         if (state == S_IDLE && req && op != `OP_NOP) begin
            ext_sfr_sel  <= (region(res_sec, res_off) == R_EXT) ||
                            (region(res_sec, res_off) == R_NVM);
            ext_sfr_nvm  <= (region(res_sec, res_off) == R_NVM);
            ext_sfr_addr <= res_off;
         end
         if (exec_wr && (tgt_reg == R_EXT || tgt_reg == R_NVM)) begin
            ext_sfr_wdata <= wval;
         end
         ext_sfr_we <= exec_wr && (tgt_reg == R_EXT || tgt_reg == R_NVM) &&
                       ext_sfr_hit && !ext_sfr_ro;
      end
   end

   // ------------------------------------------------
   // Display bytes
   // ------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `LCD_BYTES; i = i + 1) begin : g_lcd
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               lcd_byte[i] <= `LCD_RST;
            end else if (exec_wr && tgt_reg == R_LCD && tgt_off[4:0] == i) begin
               lcd_byte[i] <= wval;
            end
         end
         assign lcd_segments[8*i +: 8] = lcd_byte[i];
      end
   endgenerate

endmodule // sectored_data_memory_addressing

// ==== hw/sectored_memory_defs.vh ====
// Constants of the sectored data memory addressing block
// What this block does
// - Byte-wide sectors, each starting at 00H
// - Sector 4 00H-13H drives display segments
// - General RAM 80H-FFH in sectors 0,1
// - SFRs in sector 0; 40H only sector 1
// - Unused special locations read as 00H
// - Read-only SFRs ignore program writes
// - Indirect ports act on pointed location
// - First indirect port reaches sector 0 only
// - Other ports: low pointer plus sector pointer
// - Indirect ports reached via a pointer read 00H, writes ignored
// - Five pointers are real read/write storage
// - Extended direct addressing prepends sector number
// - Intermediate results land in the accumulator
// - Register-to-register moves go through accumulator
// - PC low write jumps within page
// - PC low jump inserts one dummy cycle
// - Bit set/clear keeps other bits intact
`ifndef SECTORED_MEMORY_DEFS_VH
`define SECTORED_MEMORY_DEFS_VH

// ------------------------------------------------
// Sector map
// ------------------------------------------------
`define SEC_ZERO       8'h00
`define SEC_ONE        8'h01
`define SEC_LCD        8'h04
`define GP_BASE        8'h80
`define LCD_LAST       8'h13
`define LCD_BYTES      20
`define NVM_CTRL_OFS   8'h40

// ------------------------------------------------
// Core registers in sector 0
// ------------------------------------------------
`define OFS_IND_S0     8'h00
`define OFS_PTR_S0     8'h01
`define OFS_IND_A      8'h02
`define OFS_PTR_A_LOW  8'h03
`define OFS_PTR_A_SEC  8'h04
`define OFS_ACC        8'h05
`define OFS_PC_LOW     8'h06
`define OFS_IND_B      8'h07
`define OFS_PTR_B_LOW  8'h08
`define OFS_PTR_B_SEC  8'h09

// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define ACC_RST        8'h00
`define PTR_RST        8'h00
`define LCD_RST        8'h00

// ------------------------------------------------
// Operation codes from the execution core
// ------------------------------------------------
`define OP_NOP         3'h0
`define OP_LOAD        3'h1
`define OP_STORE       3'h2
`define OP_BSET        3'h3
`define OP_BCLR        3'h4
`define OP_INC         3'h5
`define OP_DEC         3'h6
`define OP_ALU         3'h7

`endif

// ==== hw/data_ram.v ====
// General purpose RAM, 256 bytes, registered read data
module data_ram (
   input  wire       clk,
   input  wire       we,
   input  wire       re,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   output reg  [7:0] rdata
);
   reg [7:0] mem [0:255];

   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end
endmodule // data_ram

// ==== tb/sfr_model.sv ====
// Peripheral register responder on the far side of the special function port
module sfr_model #(
   parameter logic [7:0] RO_VAL = 8'h5a
) (
   input  wire logic       sys_clk,
   input  wire logic       sel,
   input  wire logic       nvm,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       we,
   output logic [7:0]      rdata,
   output logic            hit,
   output logic            ro
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rw_reg = 8'h00;
   logic [7:0] nvm_reg = 8'h00;
   // A stray strobe to the read-only slot lands here, so the bench can see it
   logic [7:0] ro_reg = RO_VAL;
   // --------------------------------
   // Decode
   // --------------------------------
   assign hit = sel && (nvm || addr == 8'h20 || addr == 8'h21);
   assign ro = sel && !nvm && addr == 8'h21;
   // Undecoded reads show a changing pattern, never a held value
   assign rdata = !hit ? {8{sys_clk}} ^ 8'ha5 : nvm ? nvm_reg :
                  ro ? ro_reg : rw_reg;
   always @(posedge sys_clk) begin
      if (we && hit && nvm) nvm_reg <= wdata;
      if (we && hit && !nvm && !ro) rw_reg <= wdata;
      if (we && hit && !nvm && ro) ro_reg <= wdata;
   end
endmodule // sfr_model

// ==== tb/sectored_data_memory_addressing_assertions.sv ====
// Port checker for the sectored data memory block
module mem_addr_checker (
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       req,
   input wire logic [2:0] op,
   input wire logic       busy,
   input wire logic       done,
   input wire logic [7:0] acc,
   input wire logic       pc_load,
   input wire logic [7:0] pc_load_value,
   input wire logic       pc_dummy,
   input wire logic       ext_sfr_sel,
   input wire logic       ext_sfr_we,
   input wire logic [7:0] ext_sfr_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   take_busy_a: assert property (req && op != 3'h0 && !busy |=> busy)
      else $error("request not taken");
   done_idle_a: assert property (done |-> !busy ##1 !done)
      else $error("done not a pulse");
   acc_change_a: assert property (!$stable(acc) |-> done)
      else $error("acc changed outside done");
   pc_pair_a: assert property (pc_load |-> pc_dummy && busy)
      else $error("jump without dummy cycle");
   dummy_done_a: assert property (pc_dummy |=> done && !pc_dummy)
      else $error("dummy cycle not single");
   pc_value_a: assert property (pc_load && $past(op, 2) == 3'h2 |-> pc_load_value == acc)
      else $error("jump value not acc");
   we_pulse_a: assert property (ext_sfr_we |-> done && ext_sfr_sel ##1 !ext_sfr_we)
      else $error("bad peripheral strobe");
   we_data_a: assert property (ext_sfr_we && $past(op, 2) == 3'h2 |-> ext_sfr_wdata == acc)
      else $error("peripheral data not acc");
endmodule // mem_addr_checker
bind sectored_data_memory_addressing mem_addr_checker i_chk (
   .sys_clk(sys_clk), .nrst(nrst), .req(req), .op(op), .busy(busy), .done(done),
   .acc(acc), .pc_load(pc_load), .pc_load_value(pc_load_value), .pc_dummy(pc_dummy),
   .ext_sfr_sel(ext_sfr_sel), .ext_sfr_we(ext_sfr_we), .ext_sfr_wdata(ext_sfr_wdata));

// ==== tb/sectored_data_memory_addressing_test.sv ====
// Self-checking bench for the sectored data memory block
`include "sectored_memory_defs.vh"
module sectored_data_memory_addressing_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, nrst = 1'b0, req = 1'b0, ext_addr = 1'b0;
   logic [2:0] op = 3'h0, bit_sel = 3'h0;
   logic [7:0] sector = 8'h00, addr = 8'h00, alu_result = 8'h00, pc_low_now = 8'h00;
   logic [7:0] s_rd, read_data, acc, pc_load_value, s_addr, s_wd, v, w, p, ra;
   logic busy, done, pc_load, pc_dummy, s_sel, s_nvm, s_we, s_hit, s_ro;
   logic [159:0] lcd_segments;
   logic [2:0] b;
   int n_fail = 0, checked = 0, cyc = 0, lat = 0, n_jump = 0, qk[$];
   logic [7:0] qv[$];
   always #5 sys_clk = ~sys_clk;
   sectored_data_memory_addressing i_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req),
      .op(op), .ext_addr(ext_addr), .sector(sector), .addr(addr), .bit_sel(bit_sel),
      .alu_result(alu_result), .pc_low_now(pc_low_now), .ext_sfr_rdata(s_rd),
      .ext_sfr_hit(s_hit), .ext_sfr_ro(s_ro), .busy(busy), .done(done),
      .read_data(read_data), .acc(acc), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .pc_dummy(pc_dummy), .ext_sfr_sel(s_sel), .ext_sfr_nvm(s_nvm), .ext_sfr_addr(s_addr),
      .ext_sfr_wdata(s_wd), .ext_sfr_we(s_we), .lcd_segments(lcd_segments));
   sfr_model i_sfr (.sys_clk(sys_clk), .sel(s_sel), .nvm(s_nvm), .addr(s_addr),
      .wdata(s_wd), .we(s_we), .rdata(s_rd), .hit(s_hit), .ro(s_ro));
   // --------------------------------
   // Compare, verdict and watchdog
   // --------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   // Kind 1 compares read_data, kind 2 the accumulator, kind 0 nothing
   always @(negedge sys_clk) begin
      if (pc_load === 1'b1 && pc_dummy === 1'b1) n_jump++;
      if (done === 1'b1 && qk.size() > 0) begin
         if (qk[0] == 1) chk("read_data", qv[0], read_data);
         if (qk[0] == 2) chk("acc", qv[0], acc);
         void'(qk.pop_front());
         void'(qv.pop_front());
      end
   end
   // --------------------------------
   // Drivers
   // --------------------------------
   task automatic op_do(input logic [2:0] o, input logic [7:0] s, a, x, input int k,
                        input logic [7:0] e);
      int n;
      @(negedge sys_clk);
      req = 1'b1;
      op = o;
      sector = s;
      ext_addr = (s != 8'h00);
      addr = a;
      bit_sel = x[2:0];
      alu_result = x;
      qk.push_back(k);
      qv.push_back(e);
      @(negedge sys_clk);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      lat = n;
      if (n >= 20) n_fail++;
   endtask
   task automatic st(input logic [7:0] s, a, x);
      op_do(`OP_ALU, 8'h00, 8'h00, x, 2, x);
      op_do(`OP_STORE, s, a, 8'h00, 0, 8'h00);
   endtask
   task automatic ld(input logic [7:0] s, a, e);
      op_do(`OP_LOAD, s, a, 8'h00, 1, e);
   endtask
   initial begin
      void'($urandom(32'hdfe3b140));
      pc_low_now = 8'($urandom);
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("acc_reset", 8'h00, acc);
      for (int i = 0; i < 4; i++) begin
         a_rand: begin
            ra = {1'b1, 7'($urandom)};
            v = 8'($urandom);
            st({7'h00, i[0]}, ra, v);
            op_do(`OP_ALU, 8'h00, 8'h00, ~v, 2, ~v);
            ld({7'h00, i[0]}, ra, v);
         end
      end
      $display("test ram done");
      v = 8'($urandom);
      b = 3'($urandom);
      st(8'h00, 8'hc0, v);
      op_do(`OP_BSET, 8'h00, 8'hc0, {5'h00, b}, 0, 8'h00);
      op_do(`OP_BCLR, 8'h00, 8'hc0, {5'h00, b + 3'h1}, 0, 8'h00);
      ld(8'h00, 8'hc0, (v | (8'h01 << b)) & ~(8'h01 << (b + 3'h1)));
      $display("test bits done");
      st(8'h00, 8'h01, 8'h90);
      op_do(`OP_INC, 8'h00, 8'h01, 8'h00, 0, 8'h00);
      op_do(`OP_INC, 8'h00, 8'h01, 8'h00, 0, 8'h00);
      op_do(`OP_DEC, 8'h00, 8'h01, 8'h00, 0, 8'h00);
      ld(8'h00, 8'h01, 8'h91);
      w = 8'($urandom);
      st(8'h00, 8'h91, w);
      ld(8'h00, 8'h00, w);
      st(8'h00, 8'h01, 8'h02);
      ld(8'h00, 8'h00, 8'h00);
      st(8'h00, 8'h03, 8'h85);
      st(8'h00, 8'h04, 8'h01);
      st(8'h00, 8'h02, ~w);
      ld(8'h01, 8'h85, ~w);
      st(8'h00, 8'h03, 8'h40);
      st(8'h00, 8'h02, w ^ 8'h3c);
      ld(8'h00, 8'h02, w ^ 8'h3c);
      $display("test pointers done");
      st(8'h00, 8'h08, 8'h13);
      st(8'h00, 8'h09, 8'h04);
      st(8'h00, 8'h07, w);
      @(negedge sys_clk);
      chk("lcd_byte", w, lcd_segments[159:152]);
      ld(8'h04, 8'h13, w);
      ld(8'h02, 8'h10, 8'h00);
      ld(8'h01, 8'h10, 8'h00);
      ld(8'h00, 8'h30, 8'h00);
      $display("test lcd and unused done");
      st(8'h00, 8'h20, v);
      chk("store_latency", 8'h01, 8'(lat));
      ld(8'h00, 8'h20, v);
      st(8'h00, 8'h21, ~v);
      ld(8'h00, 8'h21, 8'h5a);
      p = 8'($urandom);
      st(8'h00, 8'h06, p);
      chk("pc_load_value", p, pc_load_value);
      chk("jump_latency", 8'h02, 8'(lat));
      chk("jump_count", 8'h01, 8'(n_jump));
      ld(8'h00, 8'h06, pc_low_now);
      $display("test sfr and pc done");
      repeat (3) @(negedge sys_clk);
      give_verdict();
   end
endmodule // sectored_data_memory_addressing_test
